// ### rtl/cjtap_pkg.sv
package cjtap_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam int unsigned IR_W          = 4;
  localparam logic [3:0]  IR_BYPASS     = 4'hf;
  localparam logic [3:0]  IR_SAMPLE     = 4'h2;
  localparam logic [3:0]  IR_EXTEST     = 4'h0;
  localparam logic [3:0]  IR_HIGHZ      = 4'h9;
  localparam logic [3:0]  IR_CLAMP      = 4'hc;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;

  // ----------------------------------------------------------------
  // Boundary chain
  // ----------------------------------------------------------------
  localparam int unsigned BSR_LEN       = 63;
  localparam logic        BYPASS_CAP    = 1'b0;
  localparam logic        PULL_LEVEL    = 1'b1;

  // ----------------------------------------------------------------
  // Tap controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
  } cjtap_state_e;

  // ----------------------------------------------------------------
  // Signal pins in chain order; the last member holds position 1 at bit 0.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0]  ctrl_misc;
    logic [15:0] control_data;
    logic [15:0] match_result_low;
    logic [1:0]  mode_pin;
    logic [15:0] match_result_top;
    logic [3:0]  match_ctrl;
  } cjtap_pins_s;

  typedef struct packed {
    logic drive_test;
    logic high_z;
  } cjtap_mode_s;

endpackage : cjtap_pkg

// ### rtl/cjtap_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cjtap_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Two stages; the first stage feeds only the second.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : cjtap_sync
`default_nettype wire

// ### rtl/cjtap_top.sv
// What this block does
// - Test inputs are captured on the rising test clock and test outputs launch on the falling one.
// - The tap controller moves on the mode-select value sampled at each rising test clock.
// - An undriven mode-select input acts as a one.
// - An undriven serial data input acts as a one.
// - Serial data in is shifted on the rising test clock into the register chosen by state and instruction.
// - Serial data out changes only on the falling test clock, shows the selected register end, and is enabled by state.
// - The test reset pin forces test-logic-reset at once, without a clock.
// - Five rising test clocks with mode-select high always reach test-logic-reset.
// - Resetting the test logic never disturbs the normal pin traffic of the system.
// - The boundary chain holds 63 positions in the fixed pin order of the pin struct.
// - Instructions decode bypass 1111, sample 0010, extest 0000, high-z 1001, clamp 1100, bypass at reset.
// - Serial data out is driven only in shift-instruction and shift-data states.
// - Capture-data loads the pin values into the chain and shift-data shifts it.
// - Chain position 1 is nearest serial data out and leaves first.
`timescale 1ns/1ps
`default_nettype none

module cjtap_top (
  // System clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  NRST,
  // Test port
  input  wire logic                  TCK,
  input  wire logic                  TRST_N,
  input  wire logic                  TMS_VAL,
  input  wire logic                  TMS_DRV,
  input  wire logic                  TDI_VAL,
  input  wire logic                  TDI_DRV,
  output logic                       TDO_O,
  output logic                       TDO_OE,
  // System pins
  input  wire cjtap_pkg::cjtap_pins_s SYS_OUT,
  input  wire cjtap_pkg::cjtap_pins_s PIN_IN,
  output cjtap_pkg::cjtap_pins_s     PIN_OUT,
  output logic                       PIN_HIGHZ
);

  cjtap_pkg::cjtap_state_e st_r;
  cjtap_pkg::cjtap_state_e st_nxt;
  logic                    tms_eff;
  logic                    tdi_eff;
  logic [3:0]              ir_r;
  logic [3:0]              ir_sh_r;
  logic                    byp_r;
  logic [62:0]             bsr_r;
  logic [62:0]             upd_r;
  logic                    bsr_sel;
  cjtap_pkg::cjtap_pins_s  pins_tck;
  cjtap_pkg::cjtap_pins_s  upd_sys_r;
  cjtap_pkg::cjtap_mode_s  mode_tck;
  cjtap_pkg::cjtap_mode_s  mode_sys_r;
  logic                    shift_any;
  logic                    upd_tgl_r;
  logic                    tgl_sys;
  logic                    tgl_seen_r;
  logic                    xfer_rst_n;

  // ----------------------------------------------------------------
  // Pin pull-ups
  // ----------------------------------------------------------------
  assign tms_eff = TMS_DRV ? TMS_VAL : cjtap_pkg::PULL_LEVEL;
  assign tdi_eff = TDI_DRV ? TDI_VAL : cjtap_pkg::PULL_LEVEL;

  // ----------------------------------------------------------------
  // Tap controller
  // ----------------------------------------------------------------
  always_comb begin
    unique case (st_r)
      cjtap_pkg::ST_TLR:    st_nxt = tms_eff ? cjtap_pkg::ST_TLR    : cjtap_pkg::ST_RTI;
      cjtap_pkg::ST_RTI:    st_nxt = tms_eff ? cjtap_pkg::ST_SEL_DR : cjtap_pkg::ST_RTI;
      cjtap_pkg::ST_SEL_DR: st_nxt = tms_eff ? cjtap_pkg::ST_SEL_IR : cjtap_pkg::ST_CAP_DR;
      cjtap_pkg::ST_CAP_DR: st_nxt = tms_eff ? cjtap_pkg::ST_EX1_DR : cjtap_pkg::ST_SH_DR;
      cjtap_pkg::ST_SH_DR:  st_nxt = tms_eff ? cjtap_pkg::ST_EX1_DR : cjtap_pkg::ST_SH_DR;
      cjtap_pkg::ST_EX1_DR: st_nxt = tms_eff ? cjtap_pkg::ST_UP_DR  : cjtap_pkg::ST_PA_DR;
      cjtap_pkg::ST_PA_DR:  st_nxt = tms_eff ? cjtap_pkg::ST_EX2_DR : cjtap_pkg::ST_PA_DR;
      cjtap_pkg::ST_EX2_DR: st_nxt = tms_eff ? cjtap_pkg::ST_UP_DR  : cjtap_pkg::ST_SH_DR;
      cjtap_pkg::ST_UP_DR:  st_nxt = tms_eff ? cjtap_pkg::ST_SEL_DR : cjtap_pkg::ST_RTI;
      cjtap_pkg::ST_SEL_IR: st_nxt = tms_eff ? cjtap_pkg::ST_TLR    : cjtap_pkg::ST_CAP_IR;
      cjtap_pkg::ST_CAP_IR: st_nxt = tms_eff ? cjtap_pkg::ST_EX1_IR : cjtap_pkg::ST_SH_IR;
      cjtap_pkg::ST_SH_IR:  st_nxt = tms_eff ? cjtap_pkg::ST_EX1_IR : cjtap_pkg::ST_SH_IR;
      cjtap_pkg::ST_EX1_IR: st_nxt = tms_eff ? cjtap_pkg::ST_UP_IR  : cjtap_pkg::ST_PA_IR;
      cjtap_pkg::ST_PA_IR:  st_nxt = tms_eff ? cjtap_pkg::ST_EX2_IR : cjtap_pkg::ST_PA_IR;
      cjtap_pkg::ST_EX2_IR: st_nxt = tms_eff ? cjtap_pkg::ST_UP_IR  : cjtap_pkg::ST_SH_IR;
      cjtap_pkg::ST_UP_IR:  st_nxt = tms_eff ? cjtap_pkg::ST_SEL_DR : cjtap_pkg::ST_RTI;
    endcase
  end

  // Only the test reset pin clears this; the system reset is kept apart.
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      st_r <= cjtap_pkg::ST_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      ir_sh_r <= cjtap_pkg::IR_BYPASS;
      ir_r    <= cjtap_pkg::IR_BYPASS;
    end else begin
      if (st_r == cjtap_pkg::ST_CAP_IR) begin
        ir_sh_r <= cjtap_pkg::IR_CAPTURE;
      end else if (st_r == cjtap_pkg::ST_SH_IR) begin
        ir_sh_r <= {tdi_eff, ir_sh_r[3:1]};
      end
      if (st_r == cjtap_pkg::ST_TLR) begin
        ir_r <= cjtap_pkg::IR_BYPASS;
      end else if (st_r == cjtap_pkg::ST_UP_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // Unknown codes fall back to the bypass path.
  assign bsr_sel = (ir_r == cjtap_pkg::IR_SAMPLE) || (ir_r == cjtap_pkg::IR_EXTEST);
  assign mode_tck  = {(ir_r == cjtap_pkg::IR_EXTEST) || (ir_r == cjtap_pkg::IR_CLAMP),
                      (ir_r == cjtap_pkg::IR_HIGHZ)};
  assign shift_any = (st_r == cjtap_pkg::ST_SH_DR) || (st_r == cjtap_pkg::ST_SH_IR);

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      byp_r <= cjtap_pkg::BYPASS_CAP;
    end else if (st_r == cjtap_pkg::ST_CAP_DR) begin
      byp_r <= cjtap_pkg::BYPASS_CAP;
    end else if (st_r == cjtap_pkg::ST_SH_DR) begin
      byp_r <= tdi_eff;
    end
  end

  // Position 1 sits at bit 0, next to serial data out.
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      bsr_r <= '0;
    end else if (bsr_sel && st_r == cjtap_pkg::ST_CAP_DR) begin
      bsr_r <= pins_tck;
    end else if (bsr_sel && st_r == cjtap_pkg::ST_SH_DR) begin
      bsr_r <= {tdi_eff, bsr_r[62:1]};
    end
  end

  // Pins under extest or clamp follow only this register, so they hold while the chain shifts.
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      upd_r     <= '0;
      upd_tgl_r <= 1'b0;
    end else begin
      if (bsr_sel && st_r == cjtap_pkg::ST_UP_DR) begin
        upd_r <= bsr_r;
      end
      if ((st_r == cjtap_pkg::ST_UP_IR) || (bsr_sel && st_r == cjtap_pkg::ST_UP_DR)
          || (st_r == cjtap_pkg::ST_TLR && ir_r != cjtap_pkg::IR_BYPASS)) begin
        upd_tgl_r <= !upd_tgl_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      TDO_O  <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO_OE <= shift_any;
      if (st_r == cjtap_pkg::ST_SH_IR) begin
        TDO_O <= ir_sh_r[0];
      end else if (bsr_sel) begin
        TDO_O <= bsr_r[0];
      end else begin
        TDO_O <= byp_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock crossings
  // ----------------------------------------------------------------
  // Pins are independent levels, so a per-bit double flop is adequate for sampling.
  cjtap_sync #(.W(cjtap_pkg::BSR_LEN)) u_pins_sync (
    .clk   (TCK),
    .rst_n (TRST_N),
    .d     (PIN_IN),
    .q     (pins_tck)
  );

  // Only a toggle crosses, so each word must hold three system clocks; a test reset clears all.
  assign xfer_rst_n = NRST & TRST_N;
  cjtap_sync #(.W(1)) u_upd_sync (
    .clk   (CLK_SYS),
    .rst_n (xfer_rst_n),
    .d     (upd_tgl_r),
    .q     (tgl_sys)
  );
  always_ff @(posedge CLK_SYS or negedge xfer_rst_n) begin
    if (!xfer_rst_n) begin
      tgl_seen_r <= 1'b0;
      upd_sys_r  <= '0;
      mode_sys_r <= '0;
    end else if (tgl_sys != tgl_seen_r) begin
      tgl_seen_r <= tgl_sys;
      upd_sys_r  <= upd_r;
      mode_sys_r <= mode_tck;
    end
  end

  // ----------------------------------------------------------------
  // Pin output path
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PIN_OUT   <= '0;
      PIN_HIGHZ <= 1'b0;
    end else begin
      PIN_OUT   <= mode_sys_r.drive_test ? upd_sys_r : SYS_OUT;
      PIN_HIGHZ <= mode_sys_r.high_z;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_five_high;
    @(posedge TCK) disable iff (!TRST_N) tms_eff [*5] |=> st_r == cjtap_pkg::ST_TLR;
  endproperty
  a_five_high: assert property (p_five_high) else $error("five tms highs missed reset");

  property p_idle_stay;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_RTI && !tms_eff) |=> st_r == cjtap_pkg::ST_RTI;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("idle left on tms low");

  property p_ir_walk;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_SEL_DR && tms_eff) ##1 !tms_eff |=> st_r == cjtap_pkg::ST_CAP_IR;
  endproperty
  a_ir_walk: assert property (p_ir_walk) else $error("ir branch walk wrong");

  property p_tms_pull;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_RTI && !TMS_DRV) |=> st_r == cjtap_pkg::ST_SEL_DR;
  endproperty
  a_tms_pull: assert property (p_tms_pull) else $error("undriven tms not one");

  property p_tdi_pull;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_SH_DR && !bsr_sel && !TDI_DRV) |=> byp_r;
  endproperty
  a_tdi_pull: assert property (p_tdi_pull) else $error("undriven tdi not one");

  property p_bypass_reset;
    @(posedge TCK) disable iff (!TRST_N)
      st_r == cjtap_pkg::ST_TLR |=> ir_r == cjtap_pkg::IR_BYPASS;
  endproperty
  a_bypass_reset: assert property (p_bypass_reset) else $error("bypass not loaded");

  property p_oe_state;
    @(posedge TCK) disable iff (!TRST_N) TDO_OE == shift_any;
  endproperty
  a_oe_state: assert property (p_oe_state) else $error("tdo enable outside shift");

  property p_first_out;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_CAP_DR && bsr_sel) ##1 st_r == cjtap_pkg::ST_SH_DR
      |-> TDO_O == bsr_r[0];
  endproperty
  a_first_out: assert property (p_first_out) else $error("position 1 not first out");

  property p_capture;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_CAP_DR && bsr_sel) |=> bsr_r == $past(pins_tck);
  endproperty
  a_capture: assert property (p_capture) else $error("chain capture wrong");

  property p_shift_in;
    @(posedge TCK) disable iff (!TRST_N)
      (st_r == cjtap_pkg::ST_SH_DR && bsr_sel) |=> bsr_r[62] == $past(tdi_eff);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("tdi not shifted in");

  property p_sys_pass;
    @(posedge CLK_SYS) disable iff (!NRST)
      !mode_sys_r.drive_test |=> PIN_OUT == $past(SYS_OUT);
  endproperty
  a_sys_pass: assert property (p_sys_pass) else $error("system path disturbed");

endmodule : cjtap_top
`default_nettype wire

// ### tb/cjtap_tester.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Board test controller
// ----------------------------------------------------------------
module cjtap_tester (
  // Test port toward the device
  output logic      tck,
  output logic      trst_n,
  output logic      tms_val,
  output logic      tms_drv,
  output logic      tdi_val,
  output logic      tdi_drv,
  // Serial answer
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  logic moved = 1'b0;

  initial begin
    tck     = 1'b0;
    trst_n  = 1'b0;
    tms_val = 1'b1;
    tms_drv = 1'b1;
    tdi_val = 1'b1;
    tdi_drv = 1'b1;
  end

  // A released line toggles, so a design that reads it raw cannot pass by luck.
  task automatic step(input logic tms, input logic tdi, input logic md, input logic dd,
                      output logic tdo, output logic oe);
    logic lvl;
    tms_drv = md;
    tms_val = md ? tms : ~tms_val;
    tdi_drv = dd;
    tdi_val = dd ? tdi : ~tdi_val;
    #15;
    lvl = tdo_o;
    // A floating serial output reads as the inverse of its last level.
    tdo = tdo_oe ? tdo_o : ~tdo_o;
    oe  = tdo_oe;
    tck = 1'b1;
    #5;
    if (tdo_o !== lvl) moved = 1'b1;
    #10;
    tck = 1'b0;
  endtask : step

  // The clock stands still while the reset line drops.
  task automatic trst(output logic oe);
    logic t, o;
    trst_n = 1'b0;
    #10;
    oe = tdo_oe;
    step(1'b1, 1'b1, 1'b1, 1'b1, t, o);
    #5;
    trst_n = 1'b1;
  endtask : trst
endmodule : cjtap_tester

`default_nettype wire

// ### tb/test_cam_jtag_tap_boundary_scan.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module test_cam_jtag_tap_boundary_scan;
  localparam cjtap_pkg::cjtap_pins_s pin_pat = 63'h5a3c_0f96_e1d2_4b87;
  localparam cjtap_pkg::cjtap_pins_s sys_pat = 63'h2c71_9e05_b6d3_8a4f;
  localparam cjtap_pkg::cjtap_pins_s pre_pat = 63'h7e18_43a9_d52c_60b3;
  localparam logic [1:0]             byp_exp = {1'b1, cjtap_pkg::BYPASS_CAP};

  logic                   clk_sys = 1'b0;
  logic                   nrst    = 1'b0;
  logic                   tck, trst_n, tms_val, tms_drv, tdi_val, tdi_drv, tdo_o, tdo_oe;
  logic                   pin_highz;
  cjtap_pkg::cjtap_pins_s sys_out = '0;
  cjtap_pkg::cjtap_pins_s pin_in  = '0;
  cjtap_pkg::cjtap_pins_s pin_out;
  int                     err_count    = 0;
  int                     total_checks = 0;

  always #50 clk_sys = ~clk_sys;

  cjtap_top u_dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .TCK(tck), .TRST_N(trst_n), .TMS_VAL(tms_val),
    .TMS_DRV(tms_drv), .TDI_VAL(tdi_val), .TDI_DRV(tdi_drv), .TDO_O(tdo_o),
    .TDO_OE(tdo_oe), .SYS_OUT(sys_out), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_HIGHZ(pin_highz));

  cjtap_tester u_tester (
    .tck(tck), .trst_n(trst_n), .tms_val(tms_val), .tms_drv(tms_drv),
    .tdi_val(tdi_val), .tdi_drv(tdi_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

  task automatic sh(input logic tms);
    logic t, oe;
    u_tester.step(tms, 1'b1, 1'b1, 1'b1, t, oe);
  endtask : sh

  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++)
      sh(seq[i]);
  endtask : walk

  task automatic load_ir(input logic [3:0] code);
    logic t, oe;
    logic [3:0] cap;
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) begin
      u_tester.step(i == 3, code[i], 1'b1, 1'b1, t, oe);
      cap[i] = t;
    end
    `CHK(cap, 4'b0001)
    walk(8'h01, 2);
  endtask : load_ir

  task automatic scan_dr(input int n, input logic [125:0] din, input logic dd,
                         output logic [125:0] dout);
    logic t, oe;
    dout = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      u_tester.step(i == n - 1, din[i], 1'b1, dd, t, oe);
      dout[i] = t;
      `CHK(oe, 1'b1)
    end
    walk(8'h01, 2);
    `CHK(tdo_oe, 1'b0)
  endtask : scan_dr

  task automatic chk_byp();
    logic [125:0] o;
    scan_dr(2, 126'h1, 1'b1, o);
    `CHK(o[1:0], byp_exp)
  endtask : chk_byp

  // Mode changes cross into the system domain, so allow them time to land.
  task automatic sys_wait();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : sys_wait

  task automatic t_reset();
    logic oe;
    u_tester.trst(oe);
    walk(8'h02, 4);
    #1;
    `CHK(tdo_oe, 1'b1)
    u_tester.trst(oe);
    `CHK(oe, 1'b0)
    `CHK(pin_out, sys_pat)
    sh(1'b0);
    chk_byp();
    $display("t_reset done");
  endtask : t_reset

  task automatic t_sample();
    logic [125:0] o;
    load_ir(cjtap_pkg::IR_SAMPLE);
    scan_dr(126, 126'h0, 1'b0, o);
    `CHK(o[62:0], pin_pat)
    `CHK(o[125:63], 63'h7fff_ffff_ffff_ffff)
    $display("t_sample done");
  endtask : t_sample

  task automatic t_five();
    logic t, oe;
    logic [125:0] o;
    load_ir(cjtap_pkg::IR_SAMPLE);
    u_tester.step(1'b0, 1'b1, 1'b0, 1'b1, t, oe);
    walk(8'h00, 2);
    repeat (5) u_tester.step(1'b0, 1'b1, 1'b0, 1'b1, t, oe);
    sh(1'b0);
    scan_dr(2, 126'h1, 1'b0, o);
    `CHK(o[1:0], byp_exp)
    `CHK(pin_out, sys_pat)
    $display("t_five done");
  endtask : t_five

  task automatic t_modes();
    logic [125:0] o;
    load_ir(cjtap_pkg::IR_SAMPLE);
    scan_dr(63, {63'h0, pre_pat}, 1'b1, o);
    load_ir(cjtap_pkg::IR_EXTEST);
    sys_wait();
    `CHK(pin_out, pre_pat)
    scan_dr(63, {63'h0, pre_pat}, 1'b1, o);
    `CHK(o[62:0], pin_pat)
    load_ir(cjtap_pkg::IR_CLAMP);
    sys_wait();
    `CHK(pin_out, pre_pat)
    chk_byp();
    load_ir(cjtap_pkg::IR_HIGHZ);
    sys_wait();
    `CHK(pin_highz, 1'b1)
    chk_byp();
    load_ir(cjtap_pkg::IR_BYPASS);
    sys_wait();
    `CHK(pin_out, sys_pat)
    `CHK(pin_highz, 1'b0)
    $display("t_modes done");
  endtask : t_modes

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge clk_sys);
    nrst    <= 1'b1;
    sys_out <= sys_pat;
    pin_in  <= pin_pat;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_sample();
    t_five();
    t_modes();
    `CHK(u_tester.moved, 1'b0)
    tally_and_finish();
  end

  // The whole run needs about 16 us; over twelve times that means a hang.
  initial begin
    #200_000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : test_cam_jtag_tap_boundary_scan

`default_nettype wire
